// file: hdl/soc_power_state_controller.sv
// power-state and wake sequencer of the low-power microcontroller
`timescale 1ns/1ps
`default_nettype none
module soc_power_state_controller
  import soc_power_pkg::*;
#(
  parameter int MACROS = NUM_MACROS,
  parameter int MODULES = NUM_MODULES,
  parameter int BROWNOUTS = NUM_BROWNOUT,
  parameter int IO_WIDTH = 32,
  parameter int ENTRY_CYCLES = 4,
  parameter int PWD_CYCLES = PWD_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supplyStable,
  input wire logic lpClkTick,
  input wire logic [1:0] lowPowerRequest,
  input wire logic [NUM_RET_WAKE-1:0] wakeEnable,
  input wire logic [NUM_OFF_WAKE-1:0] offWakeEnable,
  input wire logic [MACROS-1:0] retainMacroSel,
  input wire logic [MACROS-1:0] hibernateMacroSel,
  input wire logic [WAKE_TIMER_WIDTH-1:0] offWakeTimerLoad,
  input wire logic [MODULES-1:0] moduleResetCmd,
  input wire logic cpuIdleRequest,
  input wire logic interruptPending,
  input wire logic radioSleepRequest,
  input wire logic [IO_WIDTH-1:0] ioLevel,
  input wire logic timerWakeIn,
  input wire logic gpioWakeIn,
  input wire logic keyboardWakeIn,
  input wire logic mouseWakeIn,
  input wire logic sensorThresholdIn,
  input wire logic debugConnectIn,
  input wire logic off_wake_digital_input,
  input wire logic comparator_input_a,
  input wire logic comparator_input_b,
  input wire logic power_down_pin,
  input wire logic [BROWNOUTS-1:0] brownoutIn,
  output logic chipReset_n,
  output logic [MODULES-1:0] moduleReset_n,
  output logic cpuClockGate,
  output logic radioPowerOn,
  output logic [MACROS-1:0] macroPowerOn,
  output logic flopRetain,
  output logic logicPowerOn,
  output logic pmuPowerOn,
  output logic ioHold,
  output logic [IO_WIDTH-1:0] ioHeldLevel,
  output logic timerStop,
  output logic timerClear,
  output logic offWakeTimerRun,
  output logic [BROWNOUTS-1:0] brownoutFlag,
  output primary_state_t primaryState,
  output logic pwdLengthOk
);
  // number of pins that need synchronising
  localparam int SYNC_W = 10 + BROWNOUTS;
  localparam int ENTRY_W = 8;
  localparam logic [ENTRY_W-1:0] ENTRY_LAST = ENTRY_W'(ENTRY_CYCLES - 1);
  localparam logic [PWD_CNT_WIDTH-1:0] PWD_LAST = PWD_CNT_WIDTH'(PWD_CYCLES - 1);

  typedef struct packed {
    pwr_state_t state;
    logic [1:0] target;
    logic [ENTRY_W-1:0] entryCnt;
    logic wakePending;
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    logic [MODULES-1:0] modRst;
    logic [IO_WIDTH-1:0] heldIo;
    logic hold;
    logic [WAKE_TIMER_WIDTH-1:0] offTimer;
    logic [PWD_CNT_WIDTH-1:0] pwdCnt;
    logic pwdOk;
    logic [BROWNOUTS-1:0] brown;
  } ctrl_t;

  ctrl_t cur_ff;
  ctrl_t nxt_cur;

  logic [SYNC_W-1:0] pinsRaw;
  logic retWake;
  logic offWake;
  logic pwdSync;
  logic stableSync;

  // pin order: wake pins 0-4, SoC Off pins 5-7, supply 8, power-down pin 9, brownouts above
  assign pinsRaw = {brownoutIn, power_down_pin, supplyStable, comparator_input_b, comparator_input_a,
                    off_wake_digital_input, debugConnectIn, sensorThresholdIn, mouseWakeIn,
                    keyboardWakeIn, gpioWakeIn};
  // only the second stage of each synchroniser is read
  assign stableSync = cur_ff.syncB[8];
  assign pwdSync = cur_ff.syncB[9];
  // enabled wake sources in Retention/Hibernation; the timer event is same-clock
  assign retWake = (wakeEnable[WAKE_TIMER_BIT] & timerWakeIn) |
                   (wakeEnable[WAKE_GPIO_BIT] & cur_ff.syncB[0]) |
                   (wakeEnable[WAKE_KEYBOARD_BIT] & cur_ff.syncB[1]) |
                   (wakeEnable[WAKE_MOUSE_BIT] & cur_ff.syncB[2]) |
                   (wakeEnable[WAKE_SENSOR_BIT] & cur_ff.syncB[3]) |
                   (wakeEnable[WAKE_DEBUG_BIT] & cur_ff.syncB[4]);
  // SoC Off listens to nothing but its four sources
  assign offWake = (offWakeEnable[OFF_WAKE_TIMER_BIT] && cur_ff.offTimer == '0) |
                   (offWakeEnable[OFF_WAKE_DIGITAL_BIT] & cur_ff.syncB[5]) |
                   (offWakeEnable[OFF_WAKE_COMP_A_BIT] & cur_ff.syncB[6]) |
                   (offWakeEnable[OFF_WAKE_COMP_B_BIT] & cur_ff.syncB[7]);

  // next-state logic for the whole controller
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.syncA = pinsRaw;
    nxt_cur.syncB = cur_ff.syncA;
    nxt_cur.modRst = moduleResetCmd;
    // brownout flags are level copies; there is no clear port, so nothing is sticky
    nxt_cur.brown = cur_ff.syncB[SYNC_W-1 -: BROWNOUTS];
    // power-down pin width check, counts up while asserted
    if (pwdSync) begin
      if (cur_ff.pwdCnt == PWD_LAST) begin
        nxt_cur.pwdOk = 1'b1;
      end else begin
        nxt_cur.pwdCnt = cur_ff.pwdCnt + 1'b1;
      end
    end else begin
      nxt_cur.pwdCnt = '0;
      nxt_cur.pwdOk = 1'b0;
    end
    case (cur_ff.state)
      ST_RESET: begin
        nxt_cur.hold = 1'b0;
        nxt_cur.wakePending = 1'b0;
        if (stableSync) begin
          nxt_cur.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        nxt_cur.hold = 1'b0;
        // wake selections are not latched at the request; wakeEnable and offWakeEnable are read live
        if (lowPowerRequest != REQ_NONE) begin
          nxt_cur.target = lowPowerRequest;
          nxt_cur.entryCnt = '0;
          nxt_cur.wakePending = 1'b0;
          nxt_cur.state = ST_ENTERING;
          if (lowPowerRequest != REQ_SOC_OFF) begin
            nxt_cur.heldIo = ioLevel;
            nxt_cur.hold = 1'b1;
          end
        end
      end
      ST_ENTERING: begin
        // a wake during entry is remembered, not dropped
        if (retWake) begin
          nxt_cur.wakePending = 1'b1;
        end
        if (cur_ff.entryCnt == ENTRY_LAST) begin
          if (cur_ff.wakePending || retWake) begin
            nxt_cur.state = ST_ACTIVE;
            nxt_cur.wakePending = 1'b0;
            nxt_cur.hold = 1'b0;
          end else if (cur_ff.target == REQ_RETENTION) begin
            nxt_cur.state = ST_RETENTION;
          end else if (cur_ff.target == REQ_HIBERNATION) begin
            nxt_cur.state = ST_HIBERNATION;
          end else begin
            nxt_cur.state = ST_SOC_OFF;
            nxt_cur.offTimer = offWakeTimerLoad;
          end
        end else begin
          nxt_cur.entryCnt = cur_ff.entryCnt + 1'b1;
        end
      end
      ST_RETENTION, ST_HIBERNATION: begin
        // hold drops with the wake so the pins are free as soon as Active starts
        if (retWake) begin
          nxt_cur.state = ST_ACTIVE;
          nxt_cur.hold = 1'b0;
        end
      end
      ST_SOC_OFF: begin
        if (lpClkTick && cur_ff.offTimer != '0) begin
          nxt_cur.offTimer = cur_ff.offTimer - 1'b1;
        end
        if (offWake) begin
          nxt_cur.state = ST_RESET;
        end
      end
      ST_POWERDOWN: begin
        if (!pwdSync) begin
          nxt_cur.state = ST_RESET;
        end
      end
      default: begin
        nxt_cur.state = ST_RESET;
      end
    endcase
    // the power-down pin overrides every state
    if (pwdSync) begin
      nxt_cur.state = ST_POWERDOWN;
      nxt_cur.hold = 1'b0;
    end
  end

  // single register for all controller state; it keeps clocking in retention and only rst_n clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_ff <= '0; // ST_RESET is the zero code
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // primary state and domain controls decoded from the sequencer
  always_comb begin
    primaryState = PS_ACTIVE;
    chipReset_n = 1'b1;
    logicPowerOn = 1'b1;
    pmuPowerOn = 1'b1;
    flopRetain = 1'b0;
    timerStop = 1'b0;
    timerClear = 1'b0;
    // every macro stays on in Active; Retention and Hibernation each take their own select, SoC Off and power-down turn all off
    macroPowerOn = '1;
    case (cur_ff.state)
      ST_RESET: begin
        chipReset_n = 1'b0;
        timerClear = 1'b1;
      end
      ST_ACTIVE, ST_ENTERING: begin
        primaryState = PS_ACTIVE;
      end
      ST_RETENTION: begin
        primaryState = PS_RETENTION;
        macroPowerOn = retainMacroSel;
        flopRetain = 1'b1;
        timerStop = 1'b1;
      end
      ST_HIBERNATION: begin
        primaryState = PS_HIBERNATION;
        macroPowerOn = hibernateMacroSel;
        timerStop = 1'b1;
        timerClear = 1'b1;
      end
      ST_SOC_OFF: begin
        primaryState = PS_SOC_OFF;
        macroPowerOn = '0;
        logicPowerOn = 1'b0;
        chipReset_n = 1'b0;
        timerStop = 1'b1;
      end
      ST_POWERDOWN: begin
        primaryState = PS_POWERDOWN;
        macroPowerOn = '0;
        logicPowerOn = 1'b0;
        pmuPowerOn = 1'b0;
        chipReset_n = 1'b0;
        timerStop = 1'b1;
      end
      default: begin
        chipReset_n = 1'b0;
      end
    endcase
  end

  // per-macro power, each macro from its own select bit
  // note: macros MACROS-LC_MACRO_COUNT and up serve the link controller
  // Active sub-states: idle gate drops when an interrupt arrives
  assign cpuClockGate = (cur_ff.state == ST_ACTIVE) && cpuIdleRequest && !interruptPending;
  assign radioPowerOn = (cur_ff.state == ST_ACTIVE || cur_ff.state == ST_ENTERING) && !radioSleepRequest;
  assign ioHold = cur_ff.hold;
  assign ioHeldLevel = cur_ff.heldIo;
  assign offWakeTimerRun = (cur_ff.state == ST_SOC_OFF) && offWakeEnable[OFF_WAKE_TIMER_BIT];
  assign brownoutFlag = cur_ff.brown;
  assign pwdLengthOk = cur_ff.pwdOk;

  // module resets follow the chip reset as well as their own command
  genvar gi;
  generate
    for (gi = 0; gi < MODULES; gi++) begin : g_modrst
      assign moduleReset_n[gi] = chipReset_n & ~cur_ff.modRst[gi];
    end
  endgenerate
endmodule
`default_nettype wire

// file: hdl/soc_power_pkg.sv
// shared constants and types of the power-state controller
package soc_power_pkg;
  localparam int NUM_MACROS = 8;
  localparam int LC_MACRO_COUNT = 2;
  localparam int NUM_MODULES = 8;
  localparam int NUM_BROWNOUT = 3;
  localparam int WAKE_TIMER_WIDTH = 40;
  // Retention wake sources, one bit each
  localparam int WAKE_TIMER_BIT = 0;
  localparam int WAKE_GPIO_BIT = 1;
  localparam int WAKE_KEYBOARD_BIT = 2;
  localparam int WAKE_MOUSE_BIT = 3;
  localparam int WAKE_SENSOR_BIT = 4;
  localparam int WAKE_DEBUG_BIT = 5;
  localparam int NUM_RET_WAKE = 6;
  // SoC Off wake sources
  localparam int OFF_WAKE_TIMER_BIT = 0;
  localparam int OFF_WAKE_DIGITAL_BIT = 1;
  localparam int OFF_WAKE_COMP_A_BIT = 2;
  localparam int OFF_WAKE_COMP_B_BIT = 3;
  localparam int NUM_OFF_WAKE = 4;
  // power-down pin minimum assertion
  localparam int PWD_MIN_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int PWD_MIN_CYCLES = PWD_MIN_US * CLK_MHZ;
  localparam int PWD_CNT_WIDTH = 14;
  // low-power request codes
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_RETENTION = 2'h1;
  localparam logic [1:0] REQ_HIBERNATION = 2'h2;
  localparam logic [1:0] REQ_SOC_OFF = 2'h3;
  typedef enum logic [2:0] {
    ST_RESET, ST_ACTIVE, ST_ENTERING, ST_RETENTION, ST_HIBERNATION, ST_SOC_OFF, ST_POWERDOWN
  } pwr_state_t;
  typedef enum logic [2:0] {
    PS_ACTIVE, PS_RETENTION, PS_HIBERNATION, PS_SOC_OFF, PS_POWERDOWN
  } primary_state_t;
endpackage

// file: verification/pmu_supply_model.sv
// power unit model: supplies settle a while after the unit is powered
`timescale 1ns/1ps
`default_nettype none
module pmu_supply_model (
  input wire logic core_clk,
  input wire logic pmuPowerOn,
  output logic supplyStable
);
  logic [2:0] settle = 3'h0;
  // supplies collapse with the unit and need six cycles to come back
  // an unknown enable before the first reset edge counts as off, so settle never goes unknown
  always @(posedge core_clk) begin
    if (pmuPowerOn !== 1'b1) begin
      settle <= 3'h0;
    end else if (settle != 3'h5) begin
      settle <= settle + 3'h1;
    end
    supplyStable <= (pmuPowerOn === 1'b1) && (settle == 3'h5);
  end
endmodule
`default_nettype wire

// file: verification/soc_power_checker.sv
// port-level timing checks of the power-state controller
`timescale 1ns/1ps
`default_nettype none
module soc_power_checker
  import soc_power_pkg::*;
#(
  parameter int MACROS = NUM_MACROS,
  parameter int MODULES = NUM_MODULES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supplyStable,
  input wire logic [MACROS-1:0] retainMacroSel,
  input wire logic [MACROS-1:0] hibernateMacroSel,
  input wire logic [MODULES-1:0] moduleResetCmd,
  input wire logic cpuIdleRequest,
  input wire logic interruptPending,
  input wire logic radioSleepRequest,
  input wire logic power_down_pin,
  input wire logic chipReset_n,
  input wire logic [MODULES-1:0] moduleReset_n,
  input wire logic cpuClockGate,
  input wire logic radioPowerOn,
  input wire logic [MACROS-1:0] macroPowerOn,
  input wire logic flopRetain,
  input wire logic logicPowerOn,
  input wire logic pmuPowerOn,
  input wire logic ioHold,
  input wire logic [31:0] ioHeldLevel,
  input wire logic timerStop,
  input wire logic timerClear,
  input var primary_state_t primaryState
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rel; $rose(chipReset_n) |-> $past(supplyStable, 2); endproperty
  a_rel: assert property (p_rel) else $error("reset released early");
  property p_mrst; chipReset_n && $past(chipReset_n) |-> moduleReset_n == ~$past(moduleResetCmd); endproperty
  a_mrst: assert property (p_mrst) else $error("module reset wrong");
  property p_idle; cpuClockGate |-> cpuIdleRequest && !interruptPending && primaryState == PS_ACTIVE; endproperty
  a_idle: assert property (p_idle) else $error("cpu gate wrong");
  property p_radio; radioSleepRequest |-> !radioPowerOn; endproperty
  a_radio: assert property (p_radio) else $error("radio powered");
  property p_ret; primaryState == PS_RETENTION |-> macroPowerOn == retainMacroSel && flopRetain; endproperty
  a_ret: assert property (p_ret) else $error("retention power wrong");
  property p_hib; primaryState == PS_HIBERNATION |-> macroPowerOn == hibernateMacroSel && timerClear && ioHold; endproperty
  a_hib: assert property (p_hib) else $error("hibernation power wrong");
  property p_off; primaryState == PS_SOC_OFF |-> !logicPowerOn && macroPowerOn == '0 && !chipReset_n; endproperty
  a_off: assert property (p_off) else $error("soc off power wrong");
  property p_hold; ioHold && $past(ioHold) |-> $stable(ioHeldLevel); endproperty
  a_hold: assert property (p_hold) else $error("held level moved");
  property p_pwd; power_down_pin [*5] |-> !pmuPowerOn; endproperty
  a_pwd: assert property (p_pwd) else $error("pin did not cut power");
  property p_tstop; primaryState inside {PS_RETENTION, PS_HIBERNATION, PS_SOC_OFF} |-> timerStop; endproperty
  a_tstop: assert property (p_tstop) else $error("timers run in low power");
endmodule
`default_nettype wire

// file: verification/tb.sv
// testbench of the power-state controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import soc_power_pkg::*;
  logic core_clk = 0, rst_n = 0, lpClkTick = 0, cpuIdleRequest = 0, interruptPending = 0, radioSleepRequest = 0;
  logic power_down_pin = 0, seenHib = 0, supplyStable;
  logic [1:0] lowPowerRequest = 0, tc = 0;
  logic [5:0] wakeEnable = 0, wk = 0;
  logic [3:0] offWakeEnable = 0, op = 0;
  logic [7:0] retainMacroSel = 0, hibernateMacroSel = 0, moduleResetCmd = 0, moduleReset_n, macroPowerOn;
  logic [39:0] offWakeTimerLoad = 0;
  logic [31:0] ioLevel = 0, ioHeldLevel;
  logic [2:0] brownoutIn = 0, brownoutFlag;
  logic chipReset_n, cpuClockGate, radioPowerOn, flopRetain, logicPowerOn, pmuPowerOn, ioHold;
  logic timerStop, timerClear, offWakeTimerRun, pwdLengthOk;
  primary_state_t primaryState;
  int err_count = 0, n_checks = 0;
  soc_power_state_controller #(.PWD_CYCLES(20)) i_dut (.core_clk, .rst_n, .supplyStable, .lpClkTick,
    .lowPowerRequest, .wakeEnable, .offWakeEnable, .retainMacroSel, .hibernateMacroSel, .offWakeTimerLoad,
    .moduleResetCmd, .cpuIdleRequest, .interruptPending, .radioSleepRequest, .ioLevel, .timerWakeIn(wk[0]),
    .gpioWakeIn(wk[1]), .keyboardWakeIn(wk[2]), .mouseWakeIn(wk[3]), .sensorThresholdIn(wk[4]),
    .debugConnectIn(wk[5]), .off_wake_digital_input(op[1]), .comparator_input_a(op[2]),
    .comparator_input_b(op[3]), .power_down_pin, .brownoutIn, .chipReset_n, .moduleReset_n, .cpuClockGate,
    .radioPowerOn, .macroPowerOn, .flopRetain, .logicPowerOn, .pmuPowerOn, .ioHold, .ioHeldLevel, .timerStop,
    .timerClear, .offWakeTimerRun, .brownoutFlag, .primaryState, .pwdLengthOk);
  pmu_supply_model i_pmu (.core_clk, .pmuPowerOn, .supplyStable);
  initial forever #5 core_clk = ~core_clk;
  // slow tick every fourth cycle, far faster than real but keeps the run short
  always @(posedge core_clk) begin
    tc <= tc + 2'h1;
    lpClkTick <= tc == 2'h3;
    if (primaryState === PS_HIBERNATION) seenHib <= 1'b1;
  end
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // returns on the edge itself: drives land there by non-blocking assignment, reads see pre-edge values
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic waitSt(input primary_state_t s, input logic r);
    repeat (300) begin
      if (primaryState === s && chipReset_n === r) break;
      cyc(1);
    end
    chk("state", {primaryState, chipReset_n}, {s, r});
  endtask
  task automatic enter(input logic [1:0] q);
    @(posedge core_clk);
    lowPowerRequest <= q;
    @(posedge core_clk);
    lowPowerRequest <= REQ_NONE;
    ioLevel <= 32'h0;
  endtask
  task automatic wake(input logic [5:0] v);
    @(posedge core_clk);
    wk <= v;
    cyc(4);
    wk <= 6'h0;
    cyc(3);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cut a hang short
  initial begin
    cyc(20000);
    err_count++;
    end_sim();
  end
  initial begin
    cyc(12);
    chk("rst", {chipReset_n, moduleReset_n, ioHold}, 10'h0);
    rst_n <= 1'b1;
    waitSt(PS_ACTIVE, 1'b1);
    chk("macro", macroPowerOn, 8'hFF);
    moduleResetCmd <= 8'hA5;
    cpuIdleRequest <= 1'b1;
    radioSleepRequest <= 1'b1;
    cyc(2);
    chk("mrst", {moduleReset_n, cpuClockGate, radioPowerOn}, 10'h16A);
    interruptPending <= 1'b1;
    moduleResetCmd <= 8'h0;
    radioSleepRequest <= 1'b0;
    cyc(2);
    chk("gate", {cpuClockGate, radioPowerOn}, 2'h1);
    for (int i = 0; i < 6; i++) begin
      wakeEnable <= 6'h1 << i;
      retainMacroSel <= 8'h1 << i;
      ioLevel <= 32'hA5000000 | i;
      enter(REQ_RETENTION);
      waitSt(PS_RETENTION, 1'b1);
      chk("ret", {macroPowerOn, flopRetain, timerStop, ioHold}, {8'h1 << i, 3'h7});
      chk("held", ioHeldLevel, 32'hA5000000 | i);
      wake(6'h1 << ((i + 1) % 6));
      chk("stay", primaryState, PS_RETENTION);
      wake(6'h1 << i);
      chk("woke", {primaryState, ioHold}, {PS_ACTIVE, 1'b0});
    end
    wakeEnable <= 6'h20;
    wk <= 6'h20;
    hibernateMacroSel <= 8'hC0;
    enter(REQ_HIBERNATION);
    cyc(12);
    wk <= 6'h0;
    chk("pend", {seenHib, primaryState}, {1'b0, PS_ACTIVE});
    enter(REQ_HIBERNATION);
    waitSt(PS_HIBERNATION, 1'b1);
    chk("hib", {macroPowerOn, timerClear}, 9'h181);
    wake(6'h20);
    waitSt(PS_ACTIVE, 1'b1);
    for (int i = 0; i < 4; i++) begin
      offWakeEnable <= 4'h1 << i;
      offWakeTimerLoad <= 40'h10;
      enter(REQ_SOC_OFF);
      waitSt(PS_SOC_OFF, 1'b0);
      chk("off", {offWakeTimerRun, logicPowerOn, macroPowerOn}, {i == 0, 9'h0});
      op <= ~(4'h1 << i);
      cyc(12);
      chk("offstay", primaryState, PS_SOC_OFF);
      op <= 4'h1 << i;
      waitSt(PS_ACTIVE, 1'b1);
      op <= 4'h0;
      chk("cold", {macroPowerOn, moduleReset_n, ioHold}, 17'h1FFFE);
    end
    power_down_pin <= 1'b1;
    cyc(10);
    chk("pwd", {pwdLengthOk, pmuPowerOn}, 2'h0);
    cyc(15);
    chk("pwdok", pwdLengthOk, 1'b1);
    power_down_pin <= 1'b0;
    waitSt(PS_ACTIVE, 1'b1);
    brownoutIn <= 3'h5;
    cyc(6);
    chk("brown", brownoutFlag, 3'h5);
    end_sim();
  end
endmodule
bind soc_power_state_controller soc_power_checker #(.MACROS(MACROS), .MODULES(MODULES)) i_chk (.core_clk,
  .rst_n, .supplyStable, .retainMacroSel, .hibernateMacroSel, .moduleResetCmd, .cpuIdleRequest,
  .interruptPending, .radioSleepRequest, .power_down_pin, .chipReset_n, .moduleReset_n, .cpuClockGate,
  .radioPowerOn, .macroPowerOn, .flopRetain, .logicPowerOn, .pmuPowerOn, .ioHold, .ioHeldLevel, .timerStop,
  .timerClear, .primaryState);
`default_nettype wire
